// ===== design/ssr_defines.vh
/*
 * Constants for the shared single-wire bus responder: configuration word
 * offsets, field positions, reset values, pulse classes and timing counts.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH

// ********************************************************************
// Configuration word offsets and reset values
// ********************************************************************
`define SSR_FRAME_CFG_ADDR   8'h19
`define SSR_SHARE_CFG_ADDR   8'h1b
`define SSR_CFG_W            26
`define SSR_FRAME_CFG_RESET  26'h31e6000
`define SSR_SHARE_CFG_RESET  26'h0000000

// ********************************************************************
// Field positions
// ********************************************************************
`define SSR_CAP_ADDR_BIT     0
`define SSR_FIRST_SLOT_BIT   2
`define SSR_CAP_DIS_BIT      3
`define SSR_SEL_HI           14
`define SSR_SEL_LO           12
`define SSR_TICK_HI          22
`define SSR_TICK_LO          16
`define SSR_HIGHEST_SENSOR_ID_HI         25
`define SSR_HIGHEST_SENSOR_ID_LO         24
`define SSR_START_OFF_BIT    7
`define SSR_IDLE_SYNC_BIT    8

// ********************************************************************
// Protocol selector codes
// ********************************************************************
`define SSR_SEL_SEQ          3'h6
`define SSR_SEL_SEQ_LONG     3'h7
`define SSR_SEL_ADDRESSED    3'h5

// ********************************************************************
// Function pulse windows in ticks, inclusive
// ********************************************************************
`define SSR_INC_MIN          8'h07
`define SSR_INC_MAX          8'h0a
`define SSR_OUT_MIN          8'h0c
`define SSR_OUT_MAX          8'h11
`define SSR_SMP_MIN          8'h14
`define SSR_SMP_MAX          8'h1b
`define SSR_SYN_MIN          8'h1e
`define SSR_SYN_MAX          8'h27
`define SSR_AUX_MIN          8'h2d
`define SSR_AUX_MAX          8'h3c

// ********************************************************************
// Timing
// ********************************************************************
`define SSR_CLK_PERIOD_NS    50
`define SSR_TICK_UNIT_NS     100
`define SSR_CYC_PER_UNIT     (`SSR_TICK_UNIT_NS / `SSR_CLK_PERIOD_NS)
`define SSR_IDLE_TICKS       10'h1fe
`define SSR_ID_END_TICKS     10'h012
`define SSR_FLUSH_CYCLES     4'h4

`endif

// ===== design/ssr_sync2.v
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes the inputs are asynchronous to mclk_i and change slowly
 * compared with the clock; multi-bit inputs must be quasi-static.
 */
`timescale 1ns/100ps
`default_nettype none

module ssr_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             mclk_i,
	input  wire             reset_n_i,
	input  wire [WIDTH-1:0] async_i,
	input  wire [WIDTH-1:0] reset_val_i,
	output reg  [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta;

	// The first stage feeds only the second stage.
	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			meta   <= reset_val_i;
			sync_o <= reset_val_i;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== design/ssr_tick_div.v
/*
 * Tick enable divider: one-cycle pulse every tick period.
 * Assumes period_i is in units of SSR_TICK_UNIT_NS; zero counts as one.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.vh"

module ssr_tick_div (
	input  wire       mclk_i,
	input  wire       reset_n_i,
	input  wire [6:0] period_i,
	input  wire       restart_i,
	output reg        tick_o
);

	reg  [8:0]  cnt;
	wire [8:0]  limit;
	wire [31:0] limit_full;

	// Limit in clock cycles; restart aligns ticks to line edges.
	// The product is formed at full width and then cut on purpose to the
	// counter width, which holds the largest period field times two.
	assign limit_full = (period_i == 7'h00) ? `SSR_CYC_PER_UNIT
	                  : {25'h0000000, period_i} * `SSR_CYC_PER_UNIT;
	assign limit      = limit_full[8:0];

	always @(posedge mclk_i) begin
		if (!reset_n_i || restart_i) begin
			cnt    <= 9'h000;
			tick_o <= 1'b0;
		end else if (cnt >= limit - 9'h001) begin
			cnt    <= 9'h000;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt + 9'h001;
			tick_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== design/ssr_responder.v
/*
 * Shared single-wire bus responder: measures host function pulses, keeps
 * the slot counter or increment count, selects held or fresh angle data
 * for each frame and runs the offline / alignment / online / programming
 * state machine.
 * Assumes a frame generator on mclk_i turns frame_req_o into a frame and
 * drives tx_drive_i while it wants the line low, and reports contention;
 * a Manchester decoder on mclk_i reports access, exit and bad codes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.vh"

// Notes on behaviour
// - Time every low period in ticks and classify it as a function pulse.
// - Sequential mode: addressing pulses advance slot; respond when slot equals own ID.
// - Slot counter past the highest sensor ID wraps to zero.
// - Output request sends held data if present, otherwise fresh sampled data.
// - First-slot capture: hold angle at rising edge of slot-zero output request.
// - Capture disabled and first-slot off: never hold, always send fresh data.
// - Sample pulse latches angle at its rising edge unless capture disabled.
// - Capture-addresses 0: sample is broadcast only; 1: addressed sensor also replies.
// - Slot resync makes the next addressing pulse slot zero.
// - About 18 ticks high ends counting; respond when count equals own ID.
// - Programming entry disables output; bad code before access resumes normal work.
// - After access, bad messages ignored; only exit code resumes normal work.
// - Held data is resent on each poll until a new capture.
// - Held data discarded on self-test or when the interface is disabled.
// - Offline never drives; offline after reset, programming, self-test, contention.
// - Leave offline only after pipelines flush and the line is seen high.
// - Addressed mode goes from offline straight to online.
// - Alignment state ignores addressing pulses but acts on broadcast pulses.
// - Enter online on resync, long idle with idle resync, or reset exit.
// - Online goes to programming on programming entry, offline on self-test or sequential-mode contention.
// - Protocol selector bits 14:12 and tick period bits 22:16 of word frame_config_word.
// - Highest sensor ID in bits 25:24 of word frame_config_word sets slot wraparound.
// - Idle resync enable bit 8, start-offline enable bit 7 of word bus_share_config_word.
module ssr_responder (
	input  wire                   mclk_i,
	input  wire                   reset_n_i,
	input  wire                   line_i,
	output reg                    line_o,
	output reg                    line_oe_o,
	input  wire [1:0]             sensor_id_pin_i,
	input  wire [11:0]            angle_i,
	input  wire                   tx_drive_i,
	input  wire                   contention_i,
	input  wire                   self_test_i,
	input  wire                   mch_access_i,
	input  wire                   mch_exit_i,
	input  wire                   mch_bad_i,
	input  wire                   cfg_wr_i,
	input  wire [7:0]             cfg_addr_i,
	input  wire [`SSR_CFG_W-1:0]  cfg_wdata_i,
	output reg  [`SSR_CFG_W-1:0]  cfg_rdata_o,
	output reg                    frame_req_o,
	output reg  [11:0]            frame_data_o,
	output reg  [3:0]             state_o,
	output reg  [1:0]             slot_o,
	output reg                    held_valid_o,
	output reg                    prog_wait_o
);

	// ****************************************************************
	// States
	// ****************************************************************
	localparam [3:0] ST_OFFLINE = 4'h1;
	localparam [3:0] ST_ALIGN   = 4'h2;
	localparam [3:0] ST_ONLINE  = 4'h4;
	localparam [3:0] ST_PROG    = 4'h8;

	reg  [`SSR_CFG_W-1:0] frame_cfg;
	reg  [`SSR_CFG_W-1:0] share_cfg;
	reg  [3:0]            state;
	reg  [3:0]            next_state;
	reg  [1:0]            slot;
	reg  [1:0]            next_slot;
	reg  [11:0]           held;
	reg                   held_valid;
	reg                   line_d;
	reg  [7:0]            low_ticks;
	reg  [9:0]            high_ticks;
	reg  [3:0]            flush_cnt;
	reg                   por_pending;
	reg                   access_ok;
	reg                   id_wait;
	reg  [2:0]            inc_cnt;
	wire                  line_s;
	wire [1:0]            sensor_id;
	wire                  tick;

	// ****************************************************************
	// Configuration fields
	// ****************************************************************
	wire [2:0] sel        = frame_cfg[`SSR_SEL_HI:`SSR_SEL_LO];
	wire [6:0] tick_per   = frame_cfg[`SSR_TICK_HI:`SSR_TICK_LO];
	wire [1:0] highest_id = frame_cfg[`SSR_HIGHEST_SENSOR_ID_HI:`SSR_HIGHEST_SENSOR_ID_LO];
	wire       cap_dis    = frame_cfg[`SSR_CAP_DIS_BIT];
	wire       first_slot = frame_cfg[`SSR_FIRST_SLOT_BIT];
	wire       cap_addr   = frame_cfg[`SSR_CAP_ADDR_BIT];
	wire       idle_en    = share_cfg[`SSR_IDLE_SYNC_BIT];
	wire       start_off  = share_cfg[`SSR_START_OFF_BIT];
	wire       seq_mode   = (sel == `SSR_SEL_SEQ) || (sel == `SSR_SEL_SEQ_LONG);
	wire       adr_mode   = (sel == `SSR_SEL_ADDRESSED);

	// ****************************************************************
	// Pin synchronisation and tick timing
	// ****************************************************************
	ssr_sync2 #(
		.WIDTH (3)
	) u_sync (
		.mclk_i      (mclk_i),
		.reset_n_i   (reset_n_i),
		.async_i     ({line_i, sensor_id_pin_i}),
		.reset_val_i (3'h4),
		.sync_o      ({line_s, sensor_id})
	);

	wire fall = line_d & ~line_s;
	wire rise = ~line_d & line_s;

	// Restarting on both edges keeps the tick phase tied to the pulse.
	ssr_tick_div u_tick (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.period_i  (tick_per),
		.restart_i (fall | rise),
		.tick_o    (tick)
	);

	// Low and high durations in ticks, both saturating.
	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			line_d     <= 1'b1;
			low_ticks  <= 8'h00;
			high_ticks <= 10'h000;
		end else begin
			line_d <= line_s;
			if (fall) begin
				low_ticks  <= 8'h00;
				high_ticks <= 10'h000;
			end else if (tick) begin
				if (!line_s && low_ticks != 8'hff)
					low_ticks <= low_ticks + 8'h01;
				if (line_s && high_ticks != 10'h3ff)
					high_ticks <= high_ticks + 10'h001;
			end
			if (rise)
				high_ticks <= 10'h000;
		end
	end

	// ****************************************************************
	// Pulse classification at the rising edge
	// ****************************************************************
	// Normal frame lows are shorter than every window, so they fall through.
	wire is_inc = rise && low_ticks >= `SSR_INC_MIN && low_ticks <= `SSR_INC_MAX;
	wire is_out = rise && low_ticks >= `SSR_OUT_MIN && low_ticks <= `SSR_OUT_MAX;
	wire is_smp = rise && low_ticks >= `SSR_SMP_MIN && low_ticks <= `SSR_SMP_MAX;
	wire is_syn = rise && low_ticks >= `SSR_SYN_MIN && low_ticks <= `SSR_SYN_MAX;
	wire is_aux = rise && low_ticks >= `SSR_AUX_MIN && low_ticks <= `SSR_AUX_MAX;

	wire addr_pulse = is_out | (is_smp & cap_addr);
	wire listening  = (state == ST_ONLINE) || (state == ST_ALIGN);
	wire online     = (state == ST_ONLINE);

	// Idle resync fires once, as the high time passes 510 ticks.
	wire idle_hit = idle_en && seq_mode && line_s && tick
	             && high_ticks == `SSR_IDLE_TICKS;
	wire id_end   = id_wait && line_s && high_ticks >= `SSR_ID_END_TICKS;

	// ****************************************************************
	// Capture and response decisions
	// ****************************************************************
	wire cap_smp  = listening && is_smp && !cap_dis;
	wire cap_zero = online && seq_mode && is_out && first_slot
	             && slot == 2'h0;
	wire cap_now  = cap_smp | cap_zero;
	wire discard  = self_test_i || (state == ST_PROG) || is_aux;

	// Alignment state gets no addressed answer until the slot is known.
	wire resp_seq = online && seq_mode && addr_pulse && slot == sensor_id;
	wire resp_adr = online && adr_mode && id_end
	             && inc_cnt == {1'b0, sensor_id};
	wire respond  = (resp_seq | resp_adr) && !discard;

	// Data picked for the frame: a capture in this very cycle wins.
	wire [11:0] frame_pick = cap_now ? angle_i
	                       : (held_valid ? held : angle_i);

	// ****************************************************************
	// Next state and slot
	// ****************************************************************
	always @* begin
		next_state = state;
		next_slot  = slot;
		case (state)
		ST_OFFLINE: begin
			// Pipelines flushed and line seen high before listening.
			if (flush_cnt == `SSR_FLUSH_CYCLES && !self_test_i) begin
				if (adr_mode) begin
					next_state = ST_ONLINE;
				end else if (por_pending && !start_off) begin
					next_state = ST_ONLINE;
					next_slot  = 2'h0;
				end else begin
					next_state = ST_ALIGN;
				end
			end
		end
		ST_ALIGN: begin
			if (is_syn || idle_hit) begin
				next_state = ST_ONLINE;
				next_slot  = 2'h0;
			end
			if (is_aux)
				next_state = ST_PROG;
			if (contention_i || self_test_i)
				next_state = ST_OFFLINE;
		end
		ST_ONLINE: begin
			if (seq_mode && addr_pulse) begin
				if (slot >= highest_id)
					next_slot = 2'h0;
				else
					next_slot = slot + 2'h1;
			end
			if (is_syn || idle_hit)
				next_slot = 2'h0;
			if (is_aux)
				next_state = ST_PROG;
			if ((contention_i && seq_mode) || self_test_i)
				next_state = ST_OFFLINE;
		end
		ST_PROG: begin
			if (mch_exit_i || (mch_bad_i && !access_ok && !mch_access_i))
				next_state = ST_OFFLINE;
		end
		default: begin
			next_state = ST_OFFLINE;
		end
		endcase
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			state       <= ST_OFFLINE;
			slot        <= 2'h0;
			flush_cnt   <= 4'h0;
			por_pending <= 1'b1;
			access_ok   <= 1'b0;
			id_wait     <= 1'b0;
			inc_cnt     <= 3'h0;
			held        <= 12'h000;
			held_valid  <= 1'b0;
		end else begin
			state <= next_state;
			slot  <= next_slot;
			// Flush counter needs a run of high samples while offline.
			if (state != ST_OFFLINE || !line_s)
				flush_cnt <= 4'h0;
			else if (flush_cnt != `SSR_FLUSH_CYCLES)
				flush_cnt <= flush_cnt + 4'h1;
			if (state == ST_OFFLINE && next_state != ST_OFFLINE)
				por_pending <= 1'b0;
			// Access latch: once set, bad codes no longer resume.
			if (state != ST_PROG || mch_exit_i)
				access_ok <= 1'b0;
			else if (mch_access_i)
				access_ok <= 1'b1;
			// Increment pulse counting after an addressing pulse.
			if (!online || !adr_mode || id_end) begin
				id_wait <= 1'b0;
				inc_cnt <= 3'h0;
			end
			if (online && adr_mode && addr_pulse && !id_end) begin
				id_wait <= 1'b1;
				inc_cnt <= 3'h0;
			end else if (id_wait && is_inc && inc_cnt != 3'h7) begin
				inc_cnt <= inc_cnt + 3'h1;
			end
			// Held data: discard wins over capture.
			if (discard) begin
				held_valid <= 1'b0;
			end else if (cap_now) begin
				held       <= angle_i;
				held_valid <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Configuration words
	// ****************************************************************
	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			frame_cfg <= `SSR_FRAME_CFG_RESET;
			share_cfg <= `SSR_SHARE_CFG_RESET;
		end else if (cfg_wr_i) begin
			if (cfg_addr_i == `SSR_FRAME_CFG_ADDR)
				frame_cfg <= cfg_wdata_i;
			if (cfg_addr_i == `SSR_SHARE_CFG_ADDR)
				share_cfg <= cfg_wdata_i;
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	// The line is only ever pulled low; online and transmitting is the
	// one case that enables the driver, so offline states stay silent.
	always @(posedge mclk_i) begin
		if (!reset_n_i) begin
			line_o       <= 1'b0;
			line_oe_o    <= 1'b0;
			cfg_rdata_o  <= {`SSR_CFG_W{1'b0}};
			frame_req_o  <= 1'b0;
			frame_data_o <= 12'h000;
			state_o      <= ST_OFFLINE;
			slot_o       <= 2'h0;
			held_valid_o <= 1'b0;
			prog_wait_o  <= 1'b0;
		end else begin
			line_o    <= 1'b0;
			line_oe_o <= online && tx_drive_i;
			if (cfg_addr_i == `SSR_FRAME_CFG_ADDR)
				cfg_rdata_o <= frame_cfg;
			else if (cfg_addr_i == `SSR_SHARE_CFG_ADDR)
				cfg_rdata_o <= share_cfg;
			else
				cfg_rdata_o <= {`SSR_CFG_W{1'b0}};
			frame_req_o <= respond;
			if (respond)
				frame_data_o <= frame_pick;
			state_o      <= next_state;
			slot_o       <= next_slot;
			held_valid_o <= !discard && (cap_now || held_valid);
			prog_wait_o  <= (next_state == ST_PROG);
		end
	end

endmodule

`default_nettype wire

// ===== verification/ssr_responder_properties.sv
/* Port checker for ssr_responder: state, line release and frame rules.
   Assumes it is bound to every ssr_responder instance by the bind below. */
`timescale 1ns/100ps
`default_nettype none
module ssr_responder_props (
	input wire logic       mclk_i,
	input wire logic       reset_n_i,
	input wire logic       tx_drive_i,
	input wire logic       self_test_i,
	input wire logic       mch_access_i,
	input wire logic       mch_exit_i,
	input wire logic       mch_bad_i,
	input wire logic       line_oe_o,
	input wire logic       frame_req_o,
	input wire logic [3:0] state_o,
	input wire logic       held_valid_o,
	input wire logic       prog_wait_o
);
	// ********************************************************************
	// Helper logic and properties
	// ********************************************************************
	logic acc_seen;

	// Remembers an accepted access code; a bad code is only fatal before it.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i || !prog_wait_o) acc_seen <= 1'b0;
		else if (mch_access_i) acc_seen <= 1'b1;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	tx_release_a: assert property (!$past(tx_drive_i) |-> !line_oe_o)
		else $error("line pulled low without a transmit request");
	offline_quiet_a: assert property (state_o == 4'h1 && $past(state_o) == 4'h1 |-> !line_oe_o)
		else $error("line pulled low while offline");
	prog_quiet_a: assert property (prog_wait_o && $past(prog_wait_o) |-> !line_oe_o && !held_valid_o)
		else $error("line driven or data held while programming");
	state_onehot_a: assert property ($onehot(state_o))
		else $error("state code not one-hot");
	prog_flag_a: assert property (prog_wait_o == (state_o == 4'h8))
		else $error("programming flag disagrees with state");
	frame_single_a: assert property (frame_req_o |=> !frame_req_o)
		else $error("frame request longer than one cycle");
	frame_online_a: assert property (frame_req_o |-> $past(state_o) == 4'h4)
		else $error("frame requested while not online");
	selftest_drop_a: assert property ($past(self_test_i) |-> state_o == 4'h1 && !held_valid_o)
		else $error("self-test did not force offline and discard");
	bad_early_a: assert property (prog_wait_o && !acc_seen && mch_bad_i |=> state_o == 4'h1)
		else $error("bad code before access did not resume");
	bad_late_a: assert property (prog_wait_o && acc_seen && mch_bad_i |=> prog_wait_o)
		else $error("bad code after access left programming");
	exit_off_a: assert property (prog_wait_o && mch_exit_i |=> state_o == 4'h1)
		else $error("exit code did not leave programming");
endmodule

bind ssr_responder ssr_responder_props chk_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
	.tx_drive_i(tx_drive_i), .self_test_i(self_test_i), .mch_access_i(mch_access_i),
	.mch_exit_i(mch_exit_i), .mch_bad_i(mch_bad_i), .line_oe_o(line_oe_o),
	.frame_req_o(frame_req_o), .state_o(state_o), .held_valid_o(held_valid_o),
	.prog_wait_o(prog_wait_o));
`default_nettype wire

// ===== verification/ssr_host_model.sv
/* Host controller on the shared line: issues function pulses in ticks.
   Assumes the bench forms the line as a wired-AND with a pull-up. */
`timescale 1ns/100ps
`default_nettype none
module ssr_host_model #(
	parameter int TICK_CYC = 2
) (
	input  wire logic mclk_i,
	output var  logic host_low_o
);
	// ********************************************************************
	// Pulse driver
	// ********************************************************************
	initial host_low_o = 1'b0;

	// Pulls low a whole number of ticks, then leaves the line to the pull-up.
	// The gap is short of the end-of-count time so increments stay grouped.
	task automatic pulse(input int ticks);
		host_low_o = 1'b1;
		repeat (ticks * TICK_CYC) @(posedge mclk_i);
		#1 host_low_o = 1'b0;
		repeat (12) @(posedge mclk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// ===== verification/ssr_responder_test.sv
/* Self-checking bench for ssr_responder with a host model on the line.
   Assumes the design files and ssr_defines.vh are on the include path. */
`timescale 1ns/100ps
`default_nettype none
`include "ssr_defines.vh"
module ssr_responder_test;
	// ********************************************************************
	// Stimulus, model and checks
	// ********************************************************************
	localparam int OUT = 14, SMP = 24, SYN = 34, AUX = 52, INC = 8;
	logic mclk_i = 0, reset_n_i = 0, tx_drive_i = 0, contention_i = 0, self_test_i = 0;
	logic mch_access_i = 0, mch_exit_i = 0, mch_bad_i = 0, cfg_wr_i = 0, fa, fs, ns;
	logic [11:0] angle = 12'h000;
	logic [7:0] cfg_addr = 8'h00;
	logic [25:0] cfg_wdata = 26'h0, cfg_rdata, base = 26'h2016000;
	logic line_o, line_oe, frame_req, held_valid, prog_wait, host_low;
	logic [11:0] frame_data;
	logic [3:0] state, modes[4] = '{4'h0, 4'h1, 4'h4, 4'h8};
	logic [1:0] slot;
	logic [31:0] lfsr = 32'h0776;
	wire line = !(host_low || line_oe);
	int fail_count = 0, tests_run = 0, m_slot = 0, m_id = 2, m_max = 2, m_held, m_hv = 0;
	int m_on = 1, exp_q[$], kinds[9] = '{OUT, SYN, OUT, OUT, SMP, OUT, OUT, OUT, OUT};

	ssr_responder dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .line_i(line),
		.line_o(line_o), .line_oe_o(line_oe), .sensor_id_pin_i(2'h2), .angle_i(angle),
		.tx_drive_i(tx_drive_i), .contention_i(contention_i), .self_test_i(self_test_i),
		.mch_access_i(mch_access_i), .mch_exit_i(mch_exit_i), .mch_bad_i(mch_bad_i),
		.cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
		.cfg_rdata_o(cfg_rdata), .frame_req_o(frame_req), .frame_data_o(frame_data),
		.state_o(state), .slot_o(slot), .held_valid_o(held_valid), .prog_wait_o(prog_wait));
	ssr_host_model #(.TICK_CYC(2)) host_u (.mclk_i(mclk_i), .host_low_o(host_low));

	always #25 mclk_i = ~mclk_i;

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick_wait(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [25:0] d);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr_i = 1;
		tick_wait(1);
		cfg_wr_i = 0;
	endtask

	task automatic cfg_chk(input logic [7:0] a, input logic [25:0] d);
		cfg_addr = a;
		tick_wait(2);
		check_eq(cfg_rdata, d);
	endtask

	// Predicts capture, reply and slot for one host pulse, then sends it.
	task automatic send(input int kind);
		logic adr;
		lfsr = lfsr_next(lfsr);
		angle = lfsr[11:0];
		adr = m_on && (kind == OUT || (kind == SMP && fa));
		if (kind == SMP && !ns) begin m_held = angle; m_hv = 1; end
		if (adr && kind == OUT && fs && m_slot == 0) begin m_held = angle; m_hv = 1; end
		if (adr && m_slot == m_id) exp_q.push_back(m_hv ? m_held : angle);
		if (adr) m_slot = (m_slot >= m_max) ? 0 : m_slot + 1;
		if (kind == SYN) begin m_slot = 0; m_on = 1; end
		if (kind == AUX) begin m_on = 0; m_hv = 0; end
		host_u.pulse(kind);
		check_eq(exp_q.size(), 0);
		if (m_on) check_eq(slot, m_slot);
		check_eq(held_valid, m_hv);
	endtask

	// Every frame request must carry the oldest predicted answer.
	always @(posedge mclk_i) begin
		if (frame_req === 1'b1) begin
			if (exp_q.size() == 0) check_eq(1, 0);
			else check_eq(frame_data, exp_q.pop_front());
		end
	end

	task automatic report_and_stop;
		$display("Checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Whole run is under ten thousand cycles; twice that means a hang.
	initial begin
		#(50 * 20000);
		fail_count++;
		report_and_stop();
	end

	initial begin
		tick_wait(3);
		reset_n_i = 1;
		tick_wait(10);
		check_eq(state, 4'h4);
		cfg_chk(8'h19, `SSR_FRAME_CFG_RESET);
		cfg_chk(8'h1b, `SSR_SHARE_CFG_RESET);
		cfg_wr(8'h55, 26'h3ffffff);
		cfg_chk(8'h55, 26'h0);
		cfg_wr(8'h1b, 26'h0000180);
		cfg_chk(8'h1b, 26'h0000180);
		tx_drive_i = 1;
		tick_wait(2);
		check_eq({line_oe, line_o}, 2'h2);
		tx_drive_i = 0;
		tick_wait(2);
		check_eq(line_oe, 0);
		foreach (modes[p]) begin
			fa = modes[p][0];
			fs = modes[p][2];
			ns = modes[p][3];
			// The last pass runs the long sequential selector, which decodes alike.
			if (p == 3) base[12] = 1'h1;
			cfg_wr(8'h19, base | {22'h0, modes[p]});
			cfg_chk(8'h19, base | {22'h0, modes[p]});
			foreach (kinds[k]) send(kinds[k]);
			self_test_i = 1;
			tick_wait(2);
			check_eq({state, held_valid}, {4'h1, 1'b0});
			self_test_i = 0;
			m_on = 0;
			m_hv = 0;
			tick_wait(10);
			check_eq(state, 4'h2);
		end
		tick_wait(1200);
		check_eq({state, slot}, {4'h4, 2'h0});
		m_on = 1;
		m_slot = 0;
		contention_i = 1;
		tick_wait(1);
		contention_i = 0;
		tick_wait(1);
		check_eq(state, 4'h1);
		m_on = 0;
		tick_wait(10);
		send(SYN);
		send(AUX);
		check_eq({state, prog_wait}, {4'h8, 1'h1});
		send(OUT);
		mch_bad_i = 1;
		tick_wait(1);
		mch_bad_i = 0;
		tick_wait(1);
		check_eq(state, 4'h1);
		tick_wait(10);
		send(SYN);
		send(AUX);
		mch_access_i = 1;
		tick_wait(1);
		mch_access_i = 0;
		cfg_wr(8'h19, 26'h2015000);
		mch_bad_i = 1;
		tick_wait(1);
		mch_bad_i = 0;
		tick_wait(1);
		check_eq({state, prog_wait}, {4'h8, 1'h1});
		mch_exit_i = 1;
		tick_wait(1);
		mch_exit_i = 0;
		tick_wait(1);
		check_eq(state, 4'h1);
		tick_wait(10);
		check_eq(state, 4'h4);
		for (int n = 0; n < 4; n++) begin
			lfsr = lfsr_next(lfsr);
			angle = lfsr[11:0];
			if (n == m_id) exp_q.push_back(angle);
			host_u.pulse(OUT);
			repeat (n) host_u.pulse(INC);
			tick_wait(40);
			check_eq(exp_q.size(), 0);
		end
		// A second reset must rejoin online at slot zero with no held data.
		reset_n_i = 0;
		tick_wait(3);
		reset_n_i = 1;
		tick_wait(10);
		check_eq({state, slot, held_valid}, {4'h4, 2'h0, 1'h0});
		report_and_stop();
	end
endmodule
`default_nettype wire
